// ---- inc/status_led_defines.vh ----
// constants for the fieldbus status led encoder
// assumes inclusion by bare name from design files
`ifndef STATUS_LED_DEFINES_VH
`define STATUS_LED_DEFINES_VH
// ----------------------------------------
// slave states
// ----------------------------------------
`define SLV_INIT      2'h0
`define SLV_PREOP     2'h1
`define SLV_SAFEOP    2'h2
`define SLV_OP        2'h3
// ----------------------------------------
// timing, in ns, at 125 MHz clock
// ----------------------------------------
`define CLK_PERIOD_NS 8
`define FLICKER_NS    50000000
`define BLINK_NS      200000000
`define FLASH_ON_NS   200000000
`define FLASH_OFF_NS  1000000000
`define FLICKER_CYC   (`FLICKER_NS / `CLK_PERIOD_NS)
`define BLINK_CYC     (`BLINK_NS / `CLK_PERIOD_NS)
`define FLASH_ON_CYC  (`FLASH_ON_NS / `CLK_PERIOD_NS)
`define FLASH_OFF_CYC (`FLASH_OFF_NS / `CLK_PERIOD_NS)
`endif

// ---- design/status_led_encoder.v ----
// bi-colour fieldbus status indicator encoder
// assumes state and error flags synchronous to i_clk
//
// Operation
// - green blink runs half a period out of phase with red blink; green single flash is lit in the gap slot
// - both lit at once shows red only; otherwise merge patterns
// - green: init off, preop blink, safeop single flash, op on
// - red steady on for critical comm or controller failure
// - red double flash for process data or comm watchdog timeout
// - red single flash when application changed state on local error
// - red blink for bad configuration, flicker for booting error in init
// - local or booting error sets status error indicator bit
// - red off when communication works and no error flagged
`timescale 1ns/1ps
`include "status_led_defines.vh"
module status_led_encoder #(
	parameter [31:0] FLICKER_CYC   = `FLICKER_CYC,
	parameter [31:0] BLINK_CYC     = `BLINK_CYC,
	parameter [31:0] FLASH_ON_CYC  = `FLASH_ON_CYC,
	parameter [31:0] FLASH_OFF_CYC = `FLASH_OFF_CYC
) (
	input  wire       i_clk,
	input  wire       i_arst_n,
	input  wire [1:0] i_slave_state,
	input  wire       i_crit_fail,
	input  wire       i_wdog_timeout,
	input  wire       i_local_error,
	input  wire       i_bad_config,
	input  wire       i_error_flag,
	output reg        o_led_green,
	output reg        o_led_red,
	output reg        o_al_error_ind
);
	// ----------------------------------------
	// encodings
	// ----------------------------------------
	// flash sequencer phases; the rest phase is the long dark gap
	localparam [2:0] PH_ON_A = 3'h0;
	localparam [2:0] PH_GAP  = 3'h1;
	localparam [2:0] PH_ON_B = 3'h2;
	localparam [2:0] PH_REST = 3'h3;
	// red error patterns, least to most severe
	localparam [2:0] SEV_NONE    = 3'h0;
	localparam [2:0] SEV_FLICKER = 3'h1;
	localparam [2:0] SEV_BLINK   = 3'h2;
	localparam [2:0] SEV_SINGLE  = 3'h3;
	localparam [2:0] SEV_DOUBLE  = 3'h4;
	localparam [2:0] SEV_ON      = 3'h5;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// last cycle of a divider stage; a zero length would otherwise never wrap
	function at_end;
		input [31:0] cnt;
		input [31:0] len;
		begin
			at_end = (len == 32'h0) || (cnt >= len - 32'h1);
		end
	endfunction

	// ----------------------------------------
	// divider
	// ----------------------------------------
	// three free-running bases (flicker, blink, flash), each shared by every pattern built on it
	reg [31:0] flk_cnt_r;
	reg        flk_r;
	reg [31:0] blk_cnt_r;
	reg        blk_r;
	reg [31:0] fl_cnt_r;
	reg [2:0]  fl_ph_r;
	reg        fl_tick;
	reg [2:0]  fl_ph_nxt;
	reg [31:0] fl_len;

	always @* begin
		if (fl_ph_r == PH_REST) begin
			fl_len = FLASH_OFF_CYC;
		end else begin
			fl_len = FLASH_ON_CYC;
		end
		fl_tick = at_end(fl_cnt_r, fl_len);
		case (fl_ph_r)
			PH_ON_A: fl_ph_nxt = PH_GAP;
			PH_GAP:  fl_ph_nxt = PH_ON_B;
			PH_ON_B: fl_ph_nxt = PH_REST;
			PH_REST: fl_ph_nxt = PH_ON_A;
			default: fl_ph_nxt = PH_ON_A;
		endcase
	end

	// flicker base
	always @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			flk_cnt_r <= 32'h0;
			flk_r <= 1'b0;
		end else if (at_end(flk_cnt_r, FLICKER_CYC)) begin
			flk_cnt_r <= 32'h0;
			flk_r <= ~flk_r;
		end else begin
			flk_cnt_r <= flk_cnt_r + 32'h1;
		end
	end

	// blink base, shared by red and green so they stay opposed
	always @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			blk_cnt_r <= 32'h0;
			blk_r <= 1'b0;
		end else if (at_end(blk_cnt_r, BLINK_CYC)) begin
			blk_cnt_r <= 32'h0;
			blk_r <= ~blk_r;
		end else begin
			blk_cnt_r <= blk_cnt_r + 32'h1;
		end
	end

	// flash sequencer, restarts on the first lit phase after reset
	always @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			fl_cnt_r <= 32'h0;
			fl_ph_r <= PH_ON_A;
		end else if (fl_tick) begin
			fl_cnt_r <= 32'h0;
			fl_ph_r <= fl_ph_nxt;
		end else begin
			fl_cnt_r <= fl_cnt_r + 32'h1;
		end
	end

	// ----------------------------------------
	// patterns
	// ----------------------------------------
	// green uses the opposite slots so it is lit while red's slots are dark
	reg red_blink;
	reg red_flicker;
	reg red_single;
	reg red_double;
	reg grn_blink;
	reg grn_single;

	always @* begin
		red_blink = blk_r;
		red_flicker = flk_r;
		red_single = (fl_ph_r == PH_ON_A);
		red_double = (fl_ph_r == PH_ON_A) || (fl_ph_r == PH_ON_B);
		grn_blink = ~blk_r;
		grn_single = (fl_ph_r == PH_GAP);
	end

	// ----------------------------------------
	// run indicator
	// ----------------------------------------
	reg green_req;

	always @* begin
		case (i_slave_state)
			`SLV_INIT:   green_req = 1'b0;
			`SLV_PREOP:  green_req = grn_blink;
			`SLV_SAFEOP: green_req = grn_single;
			`SLV_OP:     green_req = 1'b1;
			default:     green_req = 1'b0;
		endcase
	end

	// ----------------------------------------
	// error indicator
	// ----------------------------------------
	// only one error pattern is shown; weaker ones stay hidden until cleared
	reg       red_req;
	reg       boot_err;
	reg [2:0] sev;

	always @* begin
		boot_err = (i_slave_state == `SLV_INIT) && i_error_flag;
		if (i_crit_fail) begin
			sev = SEV_ON;
		end else if (i_wdog_timeout) begin
			sev = SEV_DOUBLE;
		end else if (i_local_error) begin
			sev = SEV_SINGLE;
		end else if (i_bad_config) begin
			sev = SEV_BLINK;
		end else if (boot_err) begin
			sev = SEV_FLICKER;
		end else begin
			sev = SEV_NONE;
		end

		case (sev)
			SEV_ON:      red_req = 1'b1;
			SEV_DOUBLE:  red_req = red_double;
			SEV_SINGLE:  red_req = red_single;
			SEV_BLINK:   red_req = red_blink;
			SEV_FLICKER: red_req = red_flicker;
			SEV_NONE:    red_req = 1'b0;
			default:     red_req = 1'b0;
		endcase
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	always @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_led_green <= 1'b0;
			o_led_red <= 1'b0;
			o_al_error_ind <= 1'b0;
		end else begin
			o_led_red <= red_req;
			o_led_green <= green_req & ~red_req;
			o_al_error_ind <= i_local_error | boot_err;
		end
	end
endmodule

// ---- verification/status_led_encoder_properties.sv ----
// checker for the status led encoder, ports only
// assumes registered outputs one cycle behind inputs
`timescale 1ns/1ps
module status_led_encoder_chk(
	input wire       i_clk,
	input wire       i_arst_n,
	input wire [1:0] i_slave_state,
	input wire       i_crit_fail,
	input wire       i_wdog_timeout,
	input wire       i_local_error,
	input wire       i_bad_config,
	input wire       i_error_flag,
	input wire       o_led_green,
	input wire       o_led_red,
	input wire       o_al_error_ind
);
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);
	wire boot = i_slave_state == 2'h0 && i_error_flag;
	wire hi   = i_crit_fail | i_wdog_timeout | i_local_error;
	wire any  = hi | i_bad_config | boot;
	property p_crit; i_crit_fail |=> o_led_red && !o_led_green; endproperty
	a_crit: assert property (p_crit) else $error("crit not steady red");
	property p_off; !any |=> !o_led_red; endproperty
	a_off: assert property (p_off) else $error("red lit without error");
	property p_op; i_slave_state == 2'h3 && !any |=> o_led_green; endproperty
	a_op: assert property (p_op) else $error("op green dark");
	property p_init; i_slave_state == 2'h0 |=> !o_led_green; endproperty
	a_init: assert property (p_init) else $error("init green lit");
	property p_excl; !(o_led_green && o_led_red); endproperty
	a_excl: assert property (p_excl) else $error("both colours lit");
	property p_ind; 1'b1 |=> o_al_error_ind == $past(i_local_error | boot); endproperty
	a_ind: assert property (p_ind) else $error("error indicator wrong");
	property p_anti; i_slave_state == 2'h1 && i_bad_config && !hi |=> o_led_green != o_led_red; endproperty
	a_anti: assert property (p_anti) else $error("blink not opposed");
	property p_merge; i_slave_state == 2'h3 && any |=> o_led_green == !o_led_red; endproperty
	a_merge: assert property (p_merge) else $error("merge wrong");
	// ----------------------------------------
	// covers
	// ----------------------------------------
	c_dbl: cover property (o_led_red ##1 !o_led_red ##[1:16] o_led_red);
	c_swap: cover property (o_led_green ##1 o_led_red);
	c_ind: cover property ($rose(o_al_error_ind));
endmodule
bind status_led_encoder status_led_encoder_chk chk(
	.i_clk          (i_clk),
	.i_arst_n       (i_arst_n),
	.i_slave_state  (i_slave_state),
	.i_crit_fail    (i_crit_fail),
	.i_wdog_timeout (i_wdog_timeout),
	.i_local_error  (i_local_error),
	.i_bad_config   (i_bad_config),
	.i_error_flag   (i_error_flag),
	.o_led_green    (o_led_green),
	.o_led_red      (o_led_red),
	.o_al_error_ind (o_al_error_ind)
);

// ---- verification/status_led_lamp.sv ----
// bi-colour lamp model: counts lit cycles and red turn-ons
// assumes high drive lights a colour
`timescale 1ns/1ps
module status_led_lamp(
	input  wire        i_clk,
	input  wire        i_green,
	input  wire        i_red,
	output reg  [31:0] o_gl = 32'h0,
	output reg  [31:0] o_rl = 32'h0,
	output reg  [31:0] o_rr = 32'h0
);
	reg was_r = 1'b0;
	always @(posedge i_clk) begin
		o_gl <= o_gl + i_green;
		o_rl <= o_rl + i_red;
		o_rr <= o_rr + (i_red & !was_r);
		was_r <= i_red;
	end
endmodule

// ---- verification/status_led_encoder_tb_top.sv ----
// bench for the status led encoder
// assumes periods shortened to 4, 8, 8, 16 cycles
`timescale 1ns/1ps
module status_led_encoder_tb_top;
	reg         i_clk = 0, i_arst_n = 0;
	reg  [1:0]  i_slave_state = 0;
	reg         i_crit_fail = 0, i_wdog_timeout = 0, i_local_error = 0, i_bad_config = 0, i_error_flag = 0;
	wire        o_led_green, o_led_red, o_al_error_ind;
	wire [31:0] gl, rl, rr;
	int         err_count = 0, n_tests = 0;
	always #4 i_clk = ~i_clk;
	status_led_encoder #(
		.FLICKER_CYC   (32'h4),
		.BLINK_CYC     (32'h8),
		.FLASH_ON_CYC  (32'h8),
		.FLASH_OFF_CYC (32'h10)
	) uut (
		.i_clk          (i_clk),
		.i_arst_n       (i_arst_n),
		.i_slave_state  (i_slave_state),
		.i_crit_fail    (i_crit_fail),
		.i_wdog_timeout (i_wdog_timeout),
		.i_local_error  (i_local_error),
		.i_bad_config   (i_bad_config),
		.i_error_flag   (i_error_flag),
		.o_led_green    (o_led_green),
		.o_led_red      (o_led_red),
		.o_al_error_ind (o_al_error_ind)
	);
	status_led_lamp lamp(.i_clk(i_clk), .i_green(o_led_green), .i_red(o_led_red), .o_gl(gl), .o_rl(rl), .o_rr(rr));
	task check(input [31:0] seen, exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task final_report;
		$display("tests=%0d errors=%0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// 80-cycle window spans whole periods, so counts do not depend on phase
	task run(input [1:0] s, input [4:0] e, input [31:0] el, er, eg);
		reg [31:0] g0, r0, q0;
		@(posedge i_clk) #1;
		i_slave_state = s;
		{i_crit_fail, i_wdog_timeout, i_local_error, i_bad_config, i_error_flag} = e;
		repeat (3) @(posedge i_clk);
		#1 check(o_al_error_ind, e[2] | (s == 2'h0 & e[0]));
		g0 = gl; r0 = rl; q0 = rr;
		repeat (80) @(posedge i_clk);
		#1 check(rl - r0, el);
		check(rr - q0, er);
		check(gl - g0, eg);
	endtask
	task t_green;
		run(2'h0, 5'h00, 0, 0, 0);
		run(2'h1, 5'h00, 0, 0, 40);
		run(2'h2, 5'h00, 0, 0, 16);
		run(2'h3, 5'h01, 0, 0, 80);
	endtask
	task t_errors;
		run(2'h3, 5'h10, 80, 0, 0);
		run(2'h3, 5'h08, 32, 4, 48);
		run(2'h3, 5'h04, 16, 2, 64);
		run(2'h3, 5'h02, 40, 5, 40);
		run(2'h1, 5'h02, 40, 5, 40);
		run(2'h0, 5'h01, 40, 10, 0);
	endtask
	task t_sev;
		run(2'h3, 5'h1f, 80, 0, 0);
		run(2'h3, 5'h0e, 32, 4, 48);
		run(2'h0, 5'h07, 16, 2, 0);
		run(2'h0, 5'h03, 40, 5, 0);
	endtask
	// mid-run reset: outputs clear at once, flash restarts on its first lit phase
	task t_reset;
		@(posedge i_clk) #1;
		i_slave_state = 2'h3;
		{i_crit_fail, i_wdog_timeout, i_local_error, i_bad_config, i_error_flag} = 5'h0c;
		repeat (2) @(posedge i_clk);
		#1 i_arst_n = 0;
		#1 check({o_led_green, o_led_red, o_al_error_ind}, 3'h0);
		@(posedge i_clk) #1;
		i_arst_n = 1;
		@(posedge i_clk) #1 check({o_led_green, o_led_red, o_al_error_ind}, 3'h3);
		repeat (8) @(posedge i_clk);
		#1 check({o_led_green, o_led_red}, 2'h2);
	endtask
	initial begin
		repeat (4) @(posedge i_clk);
		#1 i_arst_n = 1;
		t_green;
		t_errors;
		t_sev;
		t_reset;
		final_report;
	end
	initial begin
		#30000 err_count++;
		final_report;
	end
endmodule
